// >>> verilog/fpes_host.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - after error, reset before other command
// - append blocks only while timer reads zero
// - host ignores undefined status bits
// - unprotect chip only after all protected
// - keep protection pauses, never abort
module fpes_host
   import fpes_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
)(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire fpes_op_t          cmd_op,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [7:0]        cmd_data,
   input  wire logic              add_valid,
   input  wire logic [ADDR_W-1:0] add_addr,
   output logic                   add_refused,
   output logic                   done,
   output logic                   done_err,
   output logic [7:0]             last_status,
   input  wire logic              unprot_req,
   input  wire logic              all_protected,
   output logic                   unprot_go,
   output logic                   unprot_refused,
   output logic                   flash_ready,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_in,
   input  wire logic              ready_busy_n
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   // refuse an address bus too narrow for the unlock cycles
   if (ADDR_W < 12) begin : addr_w_chk
      $error("address too narrow for unlock cycles");
   end

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_RD_A, ST_RD_B, ST_RD_C, ST_EVAL, ST_ADD, ST_RST
   } fpes_st_t;

   fpes_bus_if #(.ADDR_W(ADDR_W)) bus ();
   fpes_st_t          st_reg;        // sequencer state
   fpes_op_t          op_reg;        // operation in hand
   logic [ADDR_W-1:0] addr_reg;      // target address
   logic [7:0]        data_reg;      // program data
   logic [2:0]        idx_reg;       // command sequence index
   logic [7:0]        r1_reg;        // first status read
   logic [7:0]        r2_reg;        // second status read
   logic              add_pend_reg;  // block waiting to be appended
   logic [ADDR_W-1:0] add_addr_reg;  // appended block address
   logic              rb_s1_reg;     // ready/busy sync stage one
   logic              rb_s2_reg;     // ready/busy sync stage two
   logic              toggled;       // toggle_flag moved between reads
   logic [7:0]        expect_byte;   // array value on success
   logic              checks_data;   // op ends with an array compare

   // ----------------------------------------------------------------
   // command sequence lookup: {last, address low, data}
   // ----------------------------------------------------------------
   function automatic logic [20:0] seq_word(input fpes_op_t op,
                                             input logic [2:0] i,
                                             input logic [7:0] d);
      logic [20:0] w;
      w = {1'b1, UNLOCK_ADDR1, CMD_RESET};
      unique case (op)
         FPES_OP_RESET:   w = {1'b1, UNLOCK_ADDR1, CMD_RESET};
         FPES_OP_SUSPEND: w = {1'b1, UNLOCK_ADDR1, CMD_SUSPEND};
         FPES_OP_RESUME:  w = {1'b1, UNLOCK_ADDR1, CMD_RESUME};
         FPES_OP_PROGRAM:
            unique case (i)
               3'h0:    w = {1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
               3'h1:    w = {1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
               3'h2:    w = {1'b0, UNLOCK_ADDR1, CMD_PROGRAM};
               default: w = {1'b1, UNLOCK_ADDR1, d};
            endcase
         FPES_OP_BLK_ERASE, FPES_OP_CHIP_ERASE:
            unique case (i)
               3'h0, 3'h3: w = {1'b0, UNLOCK_ADDR1, UNLOCK_DATA1};
               3'h1, 3'h4: w = {1'b0, UNLOCK_ADDR2, UNLOCK_DATA2};
               3'h2:       w = {1'b0, UNLOCK_ADDR1, CMD_ERASE};
               default:    w = {1'b1, UNLOCK_ADDR1,
                                (op == FPES_OP_CHIP_ERASE)
                                ? CMD_CHIP_ERS : CMD_BLK_ERS};
            endcase
         default: w = {1'b1, UNLOCK_ADDR1, CMD_RESET};
      endcase
      return w;
   endfunction

   logic [20:0] cur_word;            // current command write
   logic        seq_last;            // last write of the sequence
   logic        uses_target;         // final write goes to target address
   assign cur_word    = seq_word(op_reg, idx_reg, data_reg);
   assign seq_last    = cur_word[20];
   assign uses_target = seq_last && (op_reg == FPES_OP_PROGRAM ||
                                     op_reg == FPES_OP_BLK_ERASE);

   // ----------------------------------------------------------------
   // bus request drive
   // ----------------------------------------------------------------
   always_comb begin
      bus.req   = 1'b0;
      bus.wr    = 1'b0;
      bus.addr  = addr_reg;
      bus.wdata = cur_word[7:0];
      unique case (st_reg)
         ST_CMD: begin
            bus.req = 1'b1;
            bus.wr  = 1'b1;
            if (!uses_target)
               bus.addr = {{(ADDR_W-12){1'b0}}, cur_word[19:8]};
         end
         // status is read at the target, inside the block under test
         ST_RD_A, ST_RD_B, ST_RD_C: bus.req = 1'b1;
         ST_ADD: begin
            bus.req   = 1'b1;
            bus.wr    = 1'b1;
            bus.addr  = add_addr_reg;
            bus.wdata = CMD_BLK_ERS;
         end
         ST_RST: begin
            bus.req   = 1'b1;
            bus.wr    = 1'b1;
            bus.addr  = {{(ADDR_W-12){1'b0}}, UNLOCK_ADDR1};
            bus.wdata = CMD_RESET;
         end
         default: bus.req = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // decision terms; only toggle, error, timer and data are looked at
   // ----------------------------------------------------------------
   assign toggled     = r1_reg[TOGGLE_POS] ^ r2_reg[TOGGLE_POS];
   assign expect_byte = (op_reg == FPES_OP_PROGRAM) ? data_reg
                                                    : ERASED_BYTE;
   assign checks_data = op_reg == FPES_OP_PROGRAM ||
                        op_reg == FPES_OP_BLK_ERASE ||
                        op_reg == FPES_OP_CHIP_ERASE;
   assign cmd_ready   = (st_reg == ST_IDLE);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg      <= ST_IDLE;
         op_reg      <= FPES_OP_RESET;
         addr_reg    <= '0;
         data_reg    <= 8'h00;
         idx_reg     <= SEQ_IDX_RST;
         r1_reg      <= 8'h00;
         r2_reg      <= 8'h00;
         done        <= 1'b0;
         done_err    <= 1'b0;
         last_status <= 8'h00;
      end else begin
         done <= 1'b0;
         unique case (st_reg)
            // accept nothing else until the sequence has run out
            ST_IDLE: if (cmd_valid) begin
               op_reg   <= cmd_op;
               addr_reg <= cmd_addr;
               data_reg <= cmd_data;
               idx_reg  <= SEQ_IDX_RST;
               st_reg   <= ST_CMD;
            end
            // command writes; reset needs no polling afterwards
            ST_CMD: if (bus.ack) begin
               idx_reg <= idx_reg + 3'h1;
               if (seq_last)
                  st_reg <= (op_reg == FPES_OP_RESET) ? ST_EVAL : ST_RD_A;
            end
            ST_RD_A: if (bus.ack) begin
               r1_reg <= bus.rdata;
               st_reg <= ST_RD_B;
            end
            ST_RD_B: if (bus.ack) begin
               r2_reg <= bus.rdata;
               st_reg <= ST_EVAL;
            end
            // error seen while toggling: one more read to confirm
            ST_RD_C: if (bus.ack) begin
               last_status <= bus.rdata;
               if (bus.rdata[TOGGLE_POS] != r2_reg[TOGGLE_POS]) begin
                  st_reg <= ST_RST;
               end else begin
                  done     <= 1'b1;
                  done_err <= checks_data && (bus.rdata != expect_byte);
                  st_reg   <= ST_IDLE;
               end
            end
            ST_EVAL: begin
               last_status <= r2_reg;
               if (op_reg == FPES_OP_RESET) begin
                  done     <= 1'b1;
                  done_err <= 1'b0;
                  st_reg   <= ST_IDLE;
               end else if (!toggled) begin
                  // settled: aborts on protected blocks also land here
                  done     <= 1'b1;
                  done_err <= checks_data && (r2_reg != expect_byte);
                  st_reg   <= ST_IDLE;
               end else if (r2_reg[ERROR_POS]) begin
                  st_reg <= ST_RD_C;
               end else if (add_pend_reg && !r2_reg[TIMER_POS] &&
                            op_reg == FPES_OP_BLK_ERASE) begin
                  st_reg <= ST_ADD;
               end else begin
                  st_reg <= ST_RD_A;
               end
            end
            ST_ADD: if (bus.ack) st_reg <= ST_RD_A;
            // read/reset after a failure, then report the error
            ST_RST: if (bus.ack) begin
               done     <= 1'b1;
               done_err <= 1'b1;
               st_reg   <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // block append request: kept until written or refused
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         add_pend_reg <= 1'b0;
         add_addr_reg <= '0;
         add_refused  <= 1'b0;
      end else begin
         add_refused <= 1'b0;
         if (add_valid && !add_pend_reg) begin
            add_pend_reg <= 1'b1;
            add_addr_reg <= add_addr;
         end else if (st_reg == ST_ADD && bus.ack) begin
            add_pend_reg <= 1'b0;
         end else if (add_pend_reg && (st_reg == ST_IDLE ||
                      (st_reg == ST_EVAL && r2_reg[TIMER_POS]))) begin
            add_pend_reg <= 1'b0;
            add_refused  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // chip unprotect gate and ready/busy monitor
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         unprot_go      <= 1'b0;
         unprot_refused <= 1'b0;
      end else begin
         unprot_go      <= unprot_req && all_protected && cmd_ready;
         unprot_refused <= unprot_req && !(all_protected && cmd_ready);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rb_s1_reg   <= 1'b0;
         rb_s2_reg   <= 1'b0;
         flash_ready <= 1'b0;
      end else begin
         rb_s1_reg   <= ready_busy_n;
         rb_s2_reg   <= rb_s1_reg;
         flash_ready <= rb_s2_reg;
      end
   end

   // ----------------------------------------------------------------
   // bus cycle engine
   // ----------------------------------------------------------------
   fpes_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .bus          (bus.engine),
      .flash_addr   (flash_addr),
      .flash_ce_n   (flash_ce_n),
      .flash_oe_n   (flash_oe_n),
      .flash_we_n   (flash_we_n),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe),
      .flash_dq_in  (flash_dq_in)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   reset_after_err_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_reg == ST_RD_C && bus.ack &&
       bus.rdata[TOGGLE_POS] != r2_reg[TOGGLE_POS])
      |=> bus.req && bus.wr && bus.wdata == CMD_RESET)
      else $error("no reset write after error");
   append_timer_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st_reg == ST_ADD) |-> !$past(r2_reg[TIMER_POS]))
      else $error("block appended after timer set");
   unprot_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      unprot_go |-> $past(all_protected) && $past(unprot_req))
      else $error("unprotect without full protection");
   no_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cmd_valid && cmd_ready) |=> !cmd_ready [*2])
      else $error("new command accepted mid sequence");
   ignore_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
      (st_reg == ST_EVAL && op_reg != FPES_OP_RESET && !toggled)
      |=> done && st_reg == ST_IDLE)
      else $error("settled status not finished");
endmodule
`default_nettype wire

// >>> verilog/fpes_pkg.sv
`default_nettype none
package fpes_pkg;
   // ----------------------------------------------------------------
   // bus timing, counted at the 50 MHz system clock
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;            // clk_sys period
   localparam int STROBE_NS     = 60;            // least strobe width
   localparam int STROBE_CYC    =                // rounded up, min 1
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_CYC      = 2;             // dq/rb synchroniser depth
   localparam int ADDR_W_DEF    = 20;            // byte-mode address width

   // ----------------------------------------------------------------
   // status word field positions
   // ----------------------------------------------------------------
   localparam int DATA_POLL_POS  = 7;            // data_poll_bit
   localparam int TOGGLE_POS     = 6;            // toggle_flag
   localparam int ERROR_POS      = 5;            // error_flag
   localparam int TIMER_POS      = 3;            // erase_timer_flag
   localparam int ALT_TOGGLE_POS = 2;            // alt_toggle_flag

   // ----------------------------------------------------------------
   // command words, byte mode
   // ----------------------------------------------------------------
   localparam logic [11:0] UNLOCK_ADDR1 = 12'hAAA;
   localparam logic [11:0] UNLOCK_ADDR2 = 12'h555;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
   localparam logic [7:0]  CMD_ERASE    = 8'h80;
   localparam logic [7:0]  CMD_BLK_ERS  = 8'h30;
   localparam logic [7:0]  CMD_CHIP_ERS = 8'h10;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
   localparam logic [7:0]  CMD_RESUME   = 8'h30;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam logic [2:0]  SEQ_IDX_RST  = 3'h0;  // sequence index at start

   // user operations
   typedef enum logic [2:0] {
      FPES_OP_PROGRAM,
      FPES_OP_BLK_ERASE,
      FPES_OP_CHIP_ERASE,
      FPES_OP_RESET,
      FPES_OP_SUSPEND,
      FPES_OP_RESUME
   } fpes_op_t;
endpackage
`default_nettype wire

// >>> verilog/fpes_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
// one flash bus cycle request between sequencer and cycle engine
interface fpes_bus_if #(parameter int ADDR_W = 20);
   logic              req;     // level, held until ack
   logic              wr;      // 1 write, 0 read
   logic [ADDR_W-1:0] addr;    // cycle address
   logic [7:0]        wdata;   // write data
   logic              ack;     // one-cycle pulse, cycle finished
   logic [7:0]        rdata;   // captured read data
   modport master (output req, wr, addr, wdata, input ack, rdata);
   modport engine (input req, wr, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// >>> verilog/fpes_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
module fpes_bus_cycle
   import fpes_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF
)(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   fpes_bus_if.engine             bus,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [7:0]             flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic [7:0]        flash_dq_in
);
   // ----------------------------------------------------------------
   // cycle state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_DONE}
      fpes_cyc_t;
   fpes_cyc_t   cyc_reg;             // cycle phase
   logic [3:0]  cnt_reg;             // strobe cycles elapsed
   logic        wr_reg;              // latched direction
   logic [7:0]  dq_s1_reg;           // synchroniser stage one
   logic [7:0]  dq_s2_reg;           // synchroniser stage two
   logic [3:0]  strobe_len;          // strobe length for this cycle

   // reads hold oe low until the data has passed the synchroniser
   assign strobe_len = wr_reg ? 4'(STROBE_CYC) : 4'(STROBE_CYC + SYNC_CYC);

   // ----------------------------------------------------------------
   // data input synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dq_s1_reg <= 8'h00;
         dq_s2_reg <= 8'h00;
      end else begin
         dq_s1_reg <= flash_dq_in;
         dq_s2_reg <= dq_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // cycle sequencing and pin drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cyc_reg      <= CY_IDLE;
         cnt_reg      <= 4'h0;
         wr_reg       <= 1'b0;
         flash_addr   <= '0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_dq_out <= 8'h00;
         flash_dq_oe  <= 1'b0;
         bus.ack      <= 1'b0;
         bus.rdata    <= 8'h00;
      end else begin
         bus.ack <= 1'b0;
         unique case (cyc_reg)
            // take a request, present address and data
            CY_IDLE: if (bus.req) begin
               wr_reg       <= bus.wr;
               flash_addr   <= bus.addr;
               flash_dq_out <= bus.wdata;
               flash_dq_oe  <= bus.wr;
               flash_ce_n   <= 1'b0;
               cyc_reg      <= CY_SETUP;
            end
            // address settled, open the strobe
            CY_SETUP: begin
               flash_we_n <= ~wr_reg;
               flash_oe_n <= wr_reg;
               cnt_reg    <= 4'h1;
               cyc_reg    <= CY_STROBE;
            end
            // hold the strobe, capture read data at its end
            CY_STROBE: if (cnt_reg == strobe_len) begin
               flash_we_n <= 1'b1;
               flash_oe_n <= 1'b1;
               bus.rdata  <= dq_s2_reg;
               bus.ack    <= 1'b1;
               cyc_reg    <= CY_DONE;
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
            // release chip enable and bus, one recovery cycle
            CY_DONE: begin
               flash_ce_n  <= 1'b1;
               flash_dq_oe <= 1'b0;
               cyc_reg     <= CY_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence we_pulse_s;
      !flash_we_n [*3] ##1 flash_we_n;
   endsequence
   we_width_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(flash_we_n) |-> we_pulse_s)
      else $error("write strobe width wrong");
endmodule
`default_nettype wire

// >>> bench/fpes_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural flash device: small array, status word while busy
module fpes_flash_model (
   input  wire logic [19:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  dq_w,
   output logic [7:0]       dq_r,
   output logic             ready_busy_n
);
   logic [7:0] mem [16];   // array, bits 3..2 pick one of four blocks
   logic [7:0] q = '0;     // byte put on the bus
   logic [7:0] tgt = '0;   // byte being programmed
   logic [3:0] ebl = '0;   // blocks under erase
   logic       susp = 0;   // erase suspended
   localparam logic [3:0] PROT = 4'h8; // block three is protected
   int         busy = 0;   // status reads left
   logic       err = 0;    // error flag
   logic       tog = 0;    // toggle phase
   logic       pgm = 0;    // next write is program data
   logic       ers = 0;    // erase setup seen
   logic       is_ers = 0; // running op is an erase
   initial foreach (mem[i]) mem[i] = 8'hFF;
   // released bus shows the inverse of the last value
   assign dq_r = (!ce_n && !oe_n) ? q : ~q;
   assign ready_busy_n = ((busy == 0) && !err) || susp;
   // -----------------------------------------------
   // command writes, taken on the rising write strobe
   // -----------------------------------------------
   always @(posedge we_n) if (!ce_n) begin
      if (pgm) begin
         pgm = 0;
         is_ers = 0;
         tgt = dq_w;
         // protected block: abort, no error, short toggle
         if (PROT[addr[3:2]]) busy = 2;
         else begin
            err = |(dq_w & ~mem[addr[3:0]]);
            mem[addr[3:0]] &= dq_w;
            busy = 3;
         end
      end else if (dq_w == 8'hF0) begin
         err = 0;
         busy = 0;
         ers = 0;
         susp = 0;
      end else if (dq_w == 8'hA0) pgm = 1;
      else if (dq_w == 8'h80) ers = 1;
      else if (ers && (dq_w == 8'h30 || dq_w == 8'h10)) begin
         ers = 0;
         is_ers = 1;
         ebl = (dq_w == 8'h10) ? ~PROT : ~PROT & (4'h1 << addr[3:2]);
         busy = (ebl == 4'h0) ? 6 : 4;
         foreach (mem[i]) if (ebl[i/4]) mem[i] = 8'hFF;
      end else if (is_ers && busy > 0 && dq_w == 8'hB0) susp = 1;
      else if (susp && dq_w == 8'h30) susp = 0;
      else if (is_ers && busy > 0 && dq_w == 8'h30 && !PROT[addr[3:2]]) begin
         ebl[addr[3:2]] = 1'b1;
         foreach (mem[i]) if (i/4 == int'(addr[3:2])) mem[i] = 8'hFF;
      end
   end
   // reads: status word while busy, except outside suspended blocks
   always @(negedge oe_n) if (!ce_n) begin
      if ((busy > 0 || err) && !(susp && !ebl[addr[3:2]])) begin
         q = {3'h0, ~tog, 2'h0, tog, ~tog};
         q[7] = is_ers ? susp : ~tgt[7];
         q[6] = tog | susp;
         q[5] = err;
         q[3] = is_ers && busy <= 2;
         q[2] = is_ers & ebl[addr[3:2]] & tog;
         tog = ~tog;
         if (!err && !susp) busy--;
      end else q = mem[addr[3:0]];
   end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
   import fpes_pkg::*;
;
   logic clk_sys = 0;
   logic rst = 1;
   logic cmd_valid = 0;
   logic unprot_req = 0;
   logic all_protected = 0;
   fpes_op_t cmd_op = FPES_OP_RESET;
   logic [19:0] cmd_addr = '0;
   logic [19:0] add_a = '0;
   logic        add_valid = 0, add_arm = 0;
   logic        add_refused, flash_ready, dq_oe;
   logic [19:0] fa;
   logic [7:0]  cmd_data = '0;
   logic [7:0]  dq_out, dq_in, last_status;
   logic        cmd_ready, done, done_err, unprot_go, unprot_refused;
   logic        ce_n, oe_n, we_n, rb_n;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   always #10 clk_sys = ~clk_sys;
   fpes_host i_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .add_valid(add_valid), .add_addr(add_a),
      .add_refused(add_refused), .done(done), .done_err(done_err),
      .last_status(last_status), .unprot_req(unprot_req),
      .all_protected(all_protected), .unprot_go(unprot_go),
      .unprot_refused(unprot_refused), .flash_ready(flash_ready),
      .flash_addr(fa),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
      .ready_busy_n(rb_n));
   fpes_flash_model i_flash (.addr(fa), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .dq_w(dq_oe ? dq_out : ~dq_out), .dq_r(dq_in),
      .ready_busy_n(rb_n));
   // ------------------------------
   // compare, operation and verdict
   // ------------------------------
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic run(fpes_op_t op, logic [19:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1;
      add_valid = add_arm;
      @(negedge clk_sys);
      cmd_valid = 0;
      add_valid = 0;
      add_arm = 0;
      while (done !== 1'b1 && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("done", 8'h01, {7'h00, done});
   endtask
   task automatic unp(logic ap, logic [7:0] exp);
      logic [7:0] seen;
      seen = '0;
      @(negedge clk_sys);
      all_protected = ap;
      unprot_req = 1;
      @(negedge clk_sys);
      unprot_req = 0;
      repeat (3) begin
         seen |= {6'h00, unprot_go, unprot_refused};
         @(negedge clk_sys);
      end
      chk("unprotect", exp, seen);
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys) rst = 0;
      run(FPES_OP_RESET, 20'h00000, 8'h00);
      chk("reset err", 8'h00, {7'h00, done_err});
      run(FPES_OP_PROGRAM, 20'h00003, 8'h5A);
      chk("program err", 8'h00, {7'h00, done_err});
      chk("program data", 8'h5A, last_status);
      $display("test program done");
      run(FPES_OP_PROGRAM, 20'h00003, 8'hFF);
      chk("raise err", 8'h01, {7'h00, done_err});
      run(FPES_OP_RESET, 20'h00000, 8'h00);
      $display("test error done");
      run(FPES_OP_BLK_ERASE, 20'h00000, 8'h00);
      chk("erase err", 8'h00, {7'h00, done_err});
      chk("erase data", 8'hFF, last_status);
      run(FPES_OP_PROGRAM, 20'h00003, 8'hA5);
      chk("reprogram err", 8'h00, {7'h00, done_err});
      $display("test erase done");
      run(FPES_OP_PROGRAM, 20'h00004, 8'h00);
      add_a = 20'h00004;
      add_arm = 1;
      run(FPES_OP_BLK_ERASE, 20'h00000, 8'h00);
      chk("append err", 8'h00, {7'h00, done_err});
      run(FPES_OP_PROGRAM, 20'h00004, 8'hFF);
      chk("appended block", 8'h00, {7'h00, done_err});
      chk("ready", 8'h01, {7'h00, flash_ready});
      run(FPES_OP_PROGRAM, 20'h0000C, 8'h00);
      chk("protect err", 8'h01, {7'h00, done_err});
      chk("protect data", 8'hFF, last_status);
      run(FPES_OP_BLK_ERASE, 20'h0000C, 8'h00);
      chk("protect erase", 8'h00, {7'h00, done_err});
      run(FPES_OP_CHIP_ERASE, 20'h00000, 8'h00);
      chk("chip erase", 8'hFF, last_status);
      run(FPES_OP_SUSPEND, 20'h00000, 8'h00);
      run(FPES_OP_RESUME, 20'h00000, 8'h00);
      chk("resume err", 8'h00, {7'h00, done_err});
      @(negedge clk_sys);
      add_valid = 1;
      @(negedge clk_sys);
      add_valid = 0;
      @(negedge clk_sys);
      chk("add refused", 8'h01, {7'h00, add_refused});
      $display("test append protect done");
      unp(1'b0, 8'h01);
      unp(1'b1, 8'h02);
      $display("test unprotect done");
      results();
   end
endmodule
`default_nettype wire
